//--- src/swgc_map.svh
// register offsets, field positions, reset values and timing figures
`ifndef SWGC_MAP_SVH
`define SWGC_MAP_SVH

`define GC1_ADDR          8'h03
`define GC2_ADDR          8'h04

`define GC1_RST           8'h04
`define GC2_DISCARD_RST   1'b1
`define GC2_DISCARD_BIT   7

`define GC1_TX_DIS_BIT    5
`define GC1_RX_DIS_BIT    4
`define GC1_BACKOFF_BIT   0

`define RDATA_RST         8'h00

`define LEN_2K_MAX        11'h7FF
`define LEN_LEGACY_MAX    11'h5EE
`define LEN_TYPE_LIMIT    16'h05DC

`define CORE_CLK_HZ       250000000
`define AGE_NORMAL_S      300
`define AGE_FAST_US       800
`define US_PER_S          1000000

`endif

//--- src/switch_global_pkg.sv
// shared types for the global switch control bank
package switch_global_pkg;

    // first control byte, bit 7 down to bit 0
    typedef struct packed {
        logic pass_all;
        logic large_pkt;
        logic tx_pause_dis;
        logic rx_pause_dis;
        logic len_check;
        logic aging_en;
        logic fast_age;
        logic aggr_backoff;
    } gc1_s;

    typedef enum logic {
        ST_STRAP = 1'b0,
        ST_RUN   = 1'b1
    } boot_e;

    typedef struct packed {
        boot_e      boot;
        gc1_s       gc1;
        logic       vlan_discard;
        logic [7:0] rdata;
    } ctl_s;

    typedef struct packed {
        logic       done;
        logic       forward;
    } pol_s;

    typedef struct packed {
        logic [39:0] cnt;
        logic        fast_armed;
        logic        fast_prev;
        logic        sweep;
    } age_s;

endpackage

//--- src/aging_timer.sv
// address table aging period timer with fast aging cycle
`timescale 1ns/1ns
`include "swgc_map.svh"

module aging_timer #(
    parameter logic [39:0] NORMAL_CYC =
        40'(64'(`AGE_NORMAL_S) * 64'(`CORE_CLK_HZ)),
    parameter logic [39:0] FAST_CYC   =
        40'(64'(`AGE_FAST_US) * 64'(`CORE_CLK_HZ) / 64'(`US_PER_S))
) (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic aging_en,
    input  wire logic fast_age,
    output logic      age_sweep
);

    // ****************************************
    // state
    // ****************************************
    switch_global_pkg::age_s st_r;
    switch_global_pkg::age_s st_nxt;
    logic [39:0]             period;

    assign period    = st_r.fast_armed ? FAST_CYC : NORMAL_CYC;
    assign age_sweep = st_r.sweep;

    always_comb begin
        st_nxt           = st_r;
        st_nxt.sweep     = 1'b0;
        st_nxt.fast_prev = fast_age;
        // a new fast request arms one shortened cycle
        if (fast_age && !st_r.fast_prev) begin
            st_nxt.fast_armed = 1'b1;
            st_nxt.cnt        = 40'h00_0000_0000;
        end
        if (!aging_en) begin
            st_nxt.cnt = 40'h00_0000_0000;
        end else if (st_r.cnt >= period - 40'h00_0000_0001) begin
            st_nxt.cnt        = 40'h00_0000_0000;
            st_nxt.sweep      = 1'b1;
            st_nxt.fast_armed = 1'b0;
        end else if (!(fast_age && !st_r.fast_prev)) begin
            st_nxt.cnt = st_r.cnt + 40'h00_0000_0001;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule

//--- src/frame_policy.sv
// per frame forward or drop decision from the global control bits
`timescale 1ns/1ns
`include "swgc_map.svh"

module frame_policy (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        pass_all,
    input  wire logic        large_pkt,
    input  wire logic        len_check,
    input  wire logic        vlan_discard,
    input  wire logic        frm_valid,
    input  wire logic        frm_bad,
    input  wire logic [10:0] frm_len,
    input  wire logic [15:0] frm_lentype,
    input  wire logic [15:0] frm_payload_len,
    input  wire logic        frm_vlan_cross,
    input  wire logic        frm_known_ucast,
    output logic             frm_done,
    output logic             frm_forward
);

    // ****************************************
    // decision
    // ****************************************
    switch_global_pkg::pol_s st_r;
    switch_global_pkg::pol_s st_nxt;
    logic                    drop_err;
    logic                    drop_size;
    logic                    drop_len;
    logic                    drop_vlan;

    assign drop_err  = frm_bad;
    assign drop_size = frm_len > (large_pkt ? `LEN_2K_MAX
                                            : `LEN_LEGACY_MAX);
    assign drop_len  = len_check && (frm_lentype < `LEN_TYPE_LIMIT)
                       && (frm_lentype != frm_payload_len);
    // only known unicast may cross when discard is off
    assign drop_vlan = frm_vlan_cross
                       && (vlan_discard || !frm_known_ucast);

    assign frm_done    = st_r.done;
    assign frm_forward = st_r.forward;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = frm_valid;
        // settings seen in the decision cycle apply to this frame only
        if (frm_valid) begin
            st_nxt.forward = pass_all
                || !(drop_err || drop_size || drop_len || drop_vlan);
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule

//--- src/switch_global_control_regs.sv
// global control register bank of the four port switch
//
// Summary of operation
// - pass-all bit forwards errored frames too
// - large-packet bit allows frames to 2K
// - tx pause-disable overrides negotiated tx pause
// - rx pause-disable overrides negotiated rx pause
// - one strap presets both pause-disable bits
// - length check drops mismatched length below 1500
// - aging enable bit gates table aging
// - fast-age bit shortens aging period to 800us
// - aggressive back-off bit, preset from strap
// - discard bit confines all frames to port-VLAN unless pass-all is set
// - discard clear lets known unicast cross
// - after fast cycle, return to 300s period
`timescale 1ns/1ns
`include "swgc_map.svh"

module switch_global_control_regs #(
    parameter logic [39:0] AGE_NORMAL_CYC =
        40'(64'(`AGE_NORMAL_S) * 64'(`CORE_CLK_HZ)),
    parameter logic [39:0] AGE_FAST_CYC =
        40'(64'(`AGE_FAST_US) * 64'(`CORE_CLK_HZ) / 64'(`US_PER_S))
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        flow_ctrl_strap_pin,
    input  wire logic        backoff_strap_pin,
    input  wire logic        an_tx_pause,
    input  wire logic        an_rx_pause,
    output logic             tx_flow_ctrl_en,
    output logic             rx_flow_ctrl_en,
    output logic             aggr_backoff_en,
    output logic             age_sweep,
    input  wire logic        frm_valid,
    input  wire logic        frm_bad,
    input  wire logic [10:0] frm_len,
    input  wire logic [15:0] frm_lentype,
    input  wire logic [15:0] frm_payload_len,
    input  wire logic        frm_vlan_cross,
    input  wire logic        frm_known_ucast,
    output logic             frm_done,
    output logic             frm_forward
);

    // ****************************************
    // register state
    // ****************************************
    switch_global_pkg::ctl_s st_r;
    switch_global_pkg::ctl_s st_nxt;

    function automatic logic addr_hit(input logic [7:0] a,
                                      input logic [7:0] target);
        addr_hit = (a == target);
    endfunction

    always_comb begin
        st_nxt = st_r;
        unique case (st_r.boot)
            switch_global_pkg::ST_STRAP: begin
                // straps are sampled on the first edge after release
                st_nxt.gc1.tx_pause_dis = flow_ctrl_strap_pin;
                st_nxt.gc1.rx_pause_dis = flow_ctrl_strap_pin;
                st_nxt.gc1.aggr_backoff = backoff_strap_pin;
                st_nxt.boot             = switch_global_pkg::ST_RUN;
            end
            switch_global_pkg::ST_RUN: begin
                if (reg_wr && addr_hit(reg_addr, `GC1_ADDR)) begin
                    st_nxt.gc1 = switch_global_pkg::gc1_s'(reg_wdata);
                end
                if (reg_wr && addr_hit(reg_addr, `GC2_ADDR)) begin
                    st_nxt.vlan_discard = reg_wdata[`GC2_DISCARD_BIT];
                end
            end
        endcase
        if (reg_rd) begin
            if (addr_hit(reg_addr, `GC1_ADDR)) begin
                st_nxt.rdata = st_r.gc1;
            end else if (addr_hit(reg_addr, `GC2_ADDR)) begin
                st_nxt.rdata = {st_r.vlan_discard, 7'h00};
            end else begin
                st_nxt.rdata = `RDATA_RST;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r.boot         <= switch_global_pkg::ST_STRAP;
            st_r.gc1          <= switch_global_pkg::gc1_s'(`GC1_RST);
            st_r.vlan_discard <= `GC2_DISCARD_RST;
            st_r.rdata        <= `RDATA_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // outputs to the MAC and fabric
    // ****************************************
    assign reg_rdata       = st_r.rdata;
    assign tx_flow_ctrl_en = an_tx_pause && !st_r.gc1.tx_pause_dis;
    assign rx_flow_ctrl_en = an_rx_pause && !st_r.gc1.rx_pause_dis;
    assign aggr_backoff_en = st_r.gc1.aggr_backoff;

    aging_timer #(
        .NORMAL_CYC (AGE_NORMAL_CYC),
        .FAST_CYC   (AGE_FAST_CYC)
    ) u_age (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .aging_en   (st_r.gc1.aging_en),
        .fast_age   (st_r.gc1.fast_age),
        .age_sweep  (age_sweep)
    );

    frame_policy u_pol (
        .core_clk        (core_clk),
        .rst_b           (rst_b),
        .pass_all        (st_r.gc1.pass_all),
        .large_pkt       (st_r.gc1.large_pkt),
        .len_check       (st_r.gc1.len_check),
        .vlan_discard    (st_r.vlan_discard),
        .frm_valid       (frm_valid),
        .frm_bad         (frm_bad),
        .frm_len         (frm_len),
        .frm_lentype     (frm_lentype),
        .frm_payload_len (frm_payload_len),
        .frm_vlan_cross  (frm_vlan_cross),
        .frm_known_ucast (frm_known_ucast),
        .frm_done        (frm_done),
        .frm_forward     (frm_forward)
    );

endmodule

//--- tb/switch_global_control_regs_properties.sv
// concurrent checks on the global control bank ports
`timescale 1ns/1ns
module swgc_checker (
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        flow_ctrl_strap_pin,
    input wire logic        backoff_strap_pin,
    input wire logic        an_tx_pause,
    input wire logic        tx_flow_ctrl_en,
    input wire logic        age_sweep,
    input wire logic        frm_valid,
    input wire logic        frm_bad,
    input wire logic [10:0] frm_len,
    input wire logic        frm_vlan_cross,
    input wire logic        frm_known_ucast,
    input wire logic        frm_done,
    input wire logic        frm_forward
);
    // ********************
    // shadow of the bank
    // ********************
    logic [7:0] g1_q;
    logic       dc_q;
    logic       up_q;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            g1_q <= 8'h04;
            dc_q <= 1'h1;
            up_q <= 1'h0;
        end else if (!up_q) begin
            up_q <= 1'h1;
            g1_q <= {2'h0, {2{flow_ctrl_strap_pin}}, 3'h2, backoff_strap_pin};
        end else if (reg_wr && reg_addr == 8'h03) begin
            g1_q <= reg_wdata;
        end else if (reg_wr && reg_addr == 8'h04) begin
            dc_q <= reg_wdata[7];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence aging_off;
        !g1_q[2] [*3];
    endsequence
    sequence frame_in;
        frm_valid && !g1_q[7];
    endsequence
    chk_tx_pause_gate: assert property (
        up_q |-> tx_flow_ctrl_en == (an_tx_pause && !g1_q[5]))
        else $error("tx flow enable wrong");
    chk_decision_latency: assert property (
        1'h1 |=> frm_done == $past(frm_valid))
        else $error("decision pulse misplaced");
    chk_bad_dropped: assert property (
        frame_in ##0 frm_bad |=> !frm_forward)
        else $error("bad frame forwarded");
    chk_pass_all: assert property (
        frm_valid && g1_q[7] |=> frm_forward)
        else $error("pass all frame dropped");
    chk_vlan_confine: assert property (
        frame_in ##0 (frm_vlan_cross && (dc_q || !frm_known_ucast))
        |=> !frm_forward) else $error("vlan crossing forwarded");
    chk_oversize_drop: assert property (
        frame_in ##0 (!g1_q[6] && frm_len > 11'h5EE) |=> !frm_forward)
        else $error("oversize frame forwarded");
    chk_read_back: assert property (
        up_q && reg_rd && reg_addr == 8'h03 |=> reg_rdata == $past(g1_q))
        else $error("read data wrong");
    chk_aging_off: assert property (
        aging_off |-> !age_sweep)
        else $error("sweep while aging off");
endmodule

//--- tb/switch_global_control_regs_tb_top.sv
// self-checking bench for the global control bank
`timescale 1ns/1ns
module switch_global_control_regs_tb_top;
    logic core_clk = 1'h0;
    logic rst_b = 1'h0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, g1, e;
    logic reg_wr, reg_rd, flow_ctrl_strap_pin, backoff_strap_pin, dc;
    logic an_tx_pause, an_rx_pause, tx_flow_ctrl_en, rx_flow_ctrl_en;
    logic aggr_backoff_en, age_sweep, frm_valid, frm_bad, frm_vlan_cross;
    logic frm_known_ucast, frm_done, frm_forward, rd_seen;
    logic [10:0] frm_len;
    logic [15:0] frm_lentype, frm_payload_len;
    logic [7:0] exp_q[$];
    int miscompares, num_checks, sweeps;
    switch_global_control_regs #(.AGE_NORMAL_CYC(40'h28),
        .AGE_FAST_CYC(40'h8)) dut (.*);
    always #2 core_clk = ~core_clk;
    // ********************
    // tasks and monitor
    // ********************
    task automatic check(input logic [7:0] got, input logic [7:0] want);
        num_checks++;
        if (got !== want) begin
            miscompares++;
            $display("wrong value at %0t: got %h exp %h", $time, got, want);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'h1;
        @(posedge core_clk);
        #1;
        reg_wr = 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        @(posedge core_clk);
        #1;
        reg_addr = a;
        reg_rd = 1'h1;
        exp_q.push_back(x);
        @(posedge core_clk);
        #1;
        reg_rd = 1'h0;
    endtask
    task automatic restart(input logic s);
        rst_b = 1'h0;
        flow_ctrl_strap_pin = s;
        backoff_strap_pin = s;
        repeat (2) @(posedge core_clk);
        #1;
        rst_b = 1'h1;
    endtask
    task automatic age(input logic [7:0] d, input int n, input int x);
        wr(8'h03, d);
        @(posedge core_clk);
        sweeps = 0;
        repeat (n) @(posedge core_clk);
        check(8'(sweeps), 8'(x));
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge core_clk) rd_seen <= reg_rd;
    always @(negedge core_clk) begin
        if (age_sweep === 1'h1) sweeps++;
        if (rd_seen === 1'h1 || frm_done === 1'h1) begin
            e = exp_q.pop_front();
            check(rd_seen === 1'h1 ? reg_rdata : {7'h0, frm_forward}, e);
        end
    end
    initial begin
        repeat (4000) @(posedge core_clk);
        miscompares++;
        print_verdict();
    end
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, frm_valid, frm_bad, frm_len,
         frm_lentype, frm_payload_len, frm_vlan_cross, frm_known_ucast} = '0;
        an_tx_pause = 1'h1;
        an_rx_pause = 1'h1;
        void'($urandom(32'hCD62));
        restart(1'h1);
        rd(8'h03, 8'h35);
        rd(8'h04, 8'h80);
        rd(8'h10, 8'h00);
        check({6'h0, tx_flow_ctrl_en, rx_flow_ctrl_en}, 8'h00);
        check({7'h0, aggr_backoff_en}, 8'h01);
        $display("test straps done");
        g1 = 8'h35;
        dc = 1'h1;
        for (int i = 0; i < 240; i++) begin
            @(posedge core_clk);
            #1;
            frm_valid = 1'h1;
            {frm_bad, frm_vlan_cross, frm_known_ucast} = 3'($urandom);
            {an_tx_pause, an_rx_pause} = 2'($urandom);
            frm_len = 11'(1400 + $urandom % 648);
            frm_payload_len = 16'(1400 + $urandom % 200);
            frm_lentype = ($urandom % 2) ? frm_payload_len : 16'($urandom % 1600);
            exp_q.push_back({7'h0, g1[7] | !(frm_bad
                | frm_len > (g1[6] ? 11'h7FF : 11'h5EE)
                | g1[3] & frm_lentype < 16'h05DC & frm_lentype != frm_payload_len
                | frm_vlan_cross & (dc | !frm_known_ucast))});
            reg_wr = (i % 6 == 0);
            reg_addr = (i % 12 == 0) ? 8'h04 : 8'h03;
            reg_wdata = 8'($urandom);
            if (reg_wr && reg_addr == 8'h03) g1 = reg_wdata;
            if (reg_wr && reg_addr == 8'h04) dc = reg_wdata[7];
        end
        @(posedge core_clk);
        #1;
        frm_valid = 1'h0;
        reg_wr = 1'h0;
        an_tx_pause = 1'h1;
        an_rx_pause = 1'h1;
        $display("test frames done");
        wr(8'h03, 8'h10);
        check({6'h0, tx_flow_ctrl_en, rx_flow_ctrl_en}, 8'h02);
        wr(8'h04, 8'h7F);
        rd(8'h04, 8'h00);
        $display("test registers done");
        age(8'h00, 100, 0);
        age(8'h06, 30, 1);
        repeat (40) @(posedge core_clk);
        check(8'(sweeps), 8'h02);
        age(8'h00, 40, 0);
        age(8'h04, 100, 2);
        $display("test aging done");
        #1;
        restart(1'h0);
        rd(8'h03, 8'h04);
        check({7'h0, tx_flow_ctrl_en}, 8'h01);
        check({6'h0, rx_flow_ctrl_en, aggr_backoff_en}, 8'h02);
        $display("test second reset done");
        print_verdict();
    end
endmodule
bind switch_global_control_regs swgc_checker chk (.*);
